/* sample_lane_packer_pkg.sv */
`default_nettype none
package sample_lane_packer_pkg;
	localparam int NUM_LANES = 8;
	localparam int NUM_CH    = 4;
	localparam int SAMPLE_W  = 9;
	localparam int OCTET_W   = 8;
	localparam int FRAME_W   = 40;
	localparam int MAX_SPF   = 8;

	localparam logic [3:0] MODE_4  = 4'h4;
	localparam logic [3:0] MODE_5  = 4'h5;
	localparam logic [3:0] MODE_6  = 4'h6;
	localparam logic [3:0] MODE_7  = 4'h7;
	localparam logic [3:0] MODE_8  = 4'h8;
	localparam logic [3:0] MODE_9  = 4'h9;
	localparam logic [3:0] MODE_10 = 4'ha;

	localparam logic [2:0]  CNT_RESET   = 3'h0;
	localparam logic [2:0]  REM_RESET   = 3'h0;
	localparam logic [7:0]  USED_RESET  = 8'h00;
	localparam logic        READY_RESET = 1'b0;

	typedef enum logic [1:0] {
		VAR_QUAD   = 2'b00,
		VAR_DUAL   = 2'b01,
		VAR_SINGLE = 2'b10
	} variant_e;

	typedef logic [SAMPLE_W-1:0] sample_t;

	typedef struct packed {
		sample_t [NUM_CH-1:0] ch;
	} sample_beat_s;

	typedef sample_beat_s [MAX_SPF-1:0] sample_frame_t;

	// Samples of each channel gathered before one frame can be packed; zero marks an unsupported mode.
	function automatic logic [3:0] samples_per_frame(input logic [3:0] mode);
		case (mode)
			MODE_4, MODE_5, MODE_7: samples_per_frame = 4'h1;
			MODE_6, MODE_8, MODE_9: samples_per_frame = 4'h2;
			MODE_10:                samples_per_frame = 4'h8;
			default:                samples_per_frame = 4'h0;
		endcase
	endfunction

	function automatic logic [2:0] octets_per_frame(input logic [3:0] mode);
		case (mode)
			MODE_4, MODE_5, MODE_6: octets_per_frame = 3'h2;
			MODE_8:                 octets_per_frame = 3'h3;
			MODE_10:                octets_per_frame = 3'h5;
			default:                octets_per_frame = 3'h1;
		endcase
	endfunction

	function automatic logic [3:0] lanes_used(input logic [3:0] mode, input variant_e variant);
		logic [3:0] nch;
		nch = (variant == VAR_QUAD) ? 4'h4 : ((variant == VAR_DUAL) ? 4'h2 : 4'h1);
		case (mode)
			MODE_4:          lanes_used = (variant == VAR_QUAD) ? 4'h3 : nch;
			MODE_5:          lanes_used = (variant == VAR_QUAD) ? 4'h2 : 4'h1;
			MODE_6:          lanes_used = (variant == VAR_QUAD) ? 4'h6 : ((variant == VAR_DUAL) ? 4'h3 : 4'h2);
			MODE_7, MODE_8:  lanes_used = nch;
			MODE_9, MODE_10: lanes_used = {nch[2:0], 1'b0};
			default:         lanes_used = 4'h0;
		endcase
	endfunction

	function automatic logic [11:0] pad12(input sample_t s);
		pad12 = {s, 3'h0};
	endfunction

	function automatic logic [9:0] pad10(input sample_t s);
		pad10 = {s, 1'h0};
	endfunction
endpackage
`default_nettype wire

/* lane_octet_shifter.sv */
`timescale 1ns/100ps
`default_nettype none
module lane_octet_shifter (
	input  wire logic                                       clk_i,
	input  wire logic                                       rst_i,
	input  wire logic                                       ce_i,
	input  wire logic                                       load_i,
	input  wire logic                                       shift_i,
	input  wire logic                                       enable_i,
	input  wire logic [sample_lane_packer_pkg::FRAME_W-1:0] frame_i,
	output logic      [sample_lane_packer_pkg::OCTET_W-1:0] octet_o,
	output logic                                            valid_o
);
	localparam int FW = sample_lane_packer_pkg::FRAME_W;
	localparam int OW = sample_lane_packer_pkg::OCTET_W;

	logic [FW-1:0] hold;
	wire  [FW-1:0] src;
	wire           step;

	assign src  = load_i ? frame_i : hold;
	assign step = load_i | shift_i;

	// Octet 0 leaves first, taken from the top so nibble 0 is its upper nibble.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold    <= '0;
			octet_o <= '0;
			valid_o <= 1'b0;
		end else if (ce_i) begin
			hold    <= step ? {src[FW-OW-1:0], {OW{1'b0}}} : hold;
			octet_o <= step ? src[FW-1:FW-OW] : '0;
			valid_o <= load_i ? enable_i : (shift_i & valid_o);
		end
	end
endmodule
`default_nettype wire

/* sample_lane_packer.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Mode 4 pads 9-bit samples to 12 bits; three, two or one lanes.
// - Mode 4 lanes: A word plus B[8:5], then B[4:0] zeros and C[8:1].
// - Mode 5 packs 8-bit samples: lane 0 A then B, quad lane 1 C then D.
// - Mode 6 packs two 12-bit samples per channel over three lanes per pair.
// - Mode 7 puts one 8-bit sample per octet, each channel on its lane.
// - Mode 8 puts two 12-bit samples in three octets of the channel lane.
// - Mode 9 uses two lanes per channel, even samples first lane, odd second.
// - Mode 10 pads to 10 bits, four words in five octets on each lane of a pair.
// - Lanes of absent channels stay unused; C and D lanes only for quad.
module sample_lane_packer (
	input  wire logic                                             clk_i,
	input  wire logic                                             rst_i,
	input  wire logic                                             ce_i,
	input  wire logic [3:0]                                       lane_packing_mode_i,
	input  wire sample_lane_packer_pkg::variant_e                 variant_i,
	input  wire logic                                             sample_valid_i,
	input  wire sample_lane_packer_pkg::sample_beat_s             sample_i,
	output logic                                                  sample_ready_o,
	output logic [sample_lane_packer_pkg::NUM_LANES-1:0][7:0]     lane_octet_o,
	output logic [sample_lane_packer_pkg::NUM_LANES-1:0]          lane_valid_o,
	output logic [sample_lane_packer_pkg::NUM_LANES-1:0]          lane_enable_o
);
	localparam int NL = sample_lane_packer_pkg::NUM_LANES;
	localparam int FW = sample_lane_packer_pkg::FRAME_W;

	sample_lane_packer_pkg::sample_frame_t samp;
	sample_lane_packer_pkg::sample_frame_t cur;
	logic [2:0]         cnt;
	logic [2:0]         rem;
	logic [NL-1:0]      used;
	logic [NL-1:0][FW-1:0] frame;
	logic [NL-1:0]      next_used;

	wire  [3:0] spf;
	wire  [2:0] noct;
	wire  [3:0] lane_count;
	wire        mode_ok;
	wire        accept;
	wire        last;
	wire        load;
	wire        shift;
	wire  [2:0] next_cnt;
	wire  [2:0] next_rem;
	wire        next_ready;

	// Builds one lane's frame, left aligned, from the samples of one frame period.
	function automatic logic [FW-1:0] build_lane(input logic [3:0] mode,
			input sample_lane_packer_pkg::variant_e variant, input int l,
			input sample_lane_packer_pkg::sample_frame_t f);
		logic has_b;
		logic quad;
		int   pr;
		int   k;
		int   ch;
		int   c4;
		has_b = (variant != sample_lane_packer_pkg::VAR_SINGLE);
		quad  = (variant == sample_lane_packer_pkg::VAR_QUAD);
		pr    = (l < 6) ? 2 * (l / 3) : 0;
		k     = l % 2;
		ch    = l / 2;
		c4    = l % 4;
		build_lane = '0;
		case (mode)
			sample_lane_packer_pkg::MODE_4: begin
				if (l == 0)
					build_lane = {sample_lane_packer_pkg::pad12(f[0].ch[0]), has_b ? f[0].ch[1][8:5] : 4'h0, 24'h0};
				else if (l == 1)
					build_lane = {f[0].ch[1][4:0], 3'h0, quad ? f[0].ch[2][8:1] : 8'h00, 24'h0};
				else if (l == 2)
					build_lane = {f[0].ch[2][0], 3'h0, sample_lane_packer_pkg::pad12(f[0].ch[3]), 24'h0};
			end
			sample_lane_packer_pkg::MODE_5: begin
				if (l == 0)
					build_lane = {f[0].ch[0][8:1], has_b ? f[0].ch[1][8:1] : 8'h00, 24'h0};
				else if (l == 1)
					build_lane = {f[0].ch[2][8:1], f[0].ch[3][8:1], 24'h0};
			end
			sample_lane_packer_pkg::MODE_6: begin
				if (l % 3 == 0)
					build_lane = {sample_lane_packer_pkg::pad12(f[0].ch[pr]), f[1].ch[pr][8:5], 24'h0};
				else if (l % 3 == 1)
					build_lane = {f[1].ch[pr][4:0], 3'h0, has_b ? f[0].ch[pr+1][8:1] : 8'h00, 24'h0};
				else
					build_lane = {f[0].ch[pr+1][0], 3'h0, sample_lane_packer_pkg::pad12(f[1].ch[pr+1]), 24'h0};
			end
			sample_lane_packer_pkg::MODE_7: begin
				build_lane = {f[0].ch[c4][8:1], 32'h0};
			end
			sample_lane_packer_pkg::MODE_8: begin
				build_lane = {sample_lane_packer_pkg::pad12(f[0].ch[c4]),
					sample_lane_packer_pkg::pad12(f[1].ch[c4]), 16'h0};
			end
			sample_lane_packer_pkg::MODE_9: begin
				build_lane = {f[k].ch[ch][8:1], 32'h0};
			end
			sample_lane_packer_pkg::MODE_10: begin
				build_lane = {sample_lane_packer_pkg::pad10(f[k].ch[ch]), sample_lane_packer_pkg::pad10(f[k+2].ch[ch]),
					sample_lane_packer_pkg::pad10(f[k+4].ch[ch]), sample_lane_packer_pkg::pad10(f[k+6].ch[ch])};
			end
			default: build_lane = '0;
		endcase
	endfunction

	assign spf        = sample_lane_packer_pkg::samples_per_frame(lane_packing_mode_i);
	assign noct       = sample_lane_packer_pkg::octets_per_frame(lane_packing_mode_i);
	assign lane_count = sample_lane_packer_pkg::lanes_used(lane_packing_mode_i, variant_i);
	assign mode_ok    = (spf != 4'h0);
	assign accept     = sample_valid_i & sample_ready_o;
	assign last       = ({1'b0, cnt} == spf - 4'h1);
	assign load       = accept & last;
	assign shift      = (rem != 3'h0) & ~load;
	assign next_cnt   = accept ? (last ? 3'h0 : cnt + 3'h1) : cnt;
	assign next_rem   = load ? noct - 3'h1 : (shift ? rem - 3'h1 : rem);
	// Holding the last sample back until the lanes drain means a frame is never overwritten mid-flight.
	assign next_ready = mode_ok & ~(({1'b0, next_cnt} == spf - 4'h1) & (next_rem != 3'h0));

	genvar g;
	generate
		for (g = 0; g < sample_lane_packer_pkg::MAX_SPF; g++) begin : g_cur
			assign cur[g] = (cnt == 3'(g)) ? sample_i : samp[g];
		end
		for (g = 0; g < NL; g++) begin : g_lane
			assign next_used[g] = (lane_count > 4'(g));
			assign frame[g]     = next_used[g] ? build_lane(lane_packing_mode_i, variant_i, g, cur) : '0;
			lane_octet_shifter u_shift (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.ce_i     (ce_i),
				.load_i   (load),
				.shift_i  (shift),
				.enable_i (next_used[g]),
				.frame_i  (frame[g]),
				.octet_o  (lane_octet_o[g]),
				.valid_o  (lane_valid_o[g])
			);
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt            <= sample_lane_packer_pkg::CNT_RESET;
			rem            <= sample_lane_packer_pkg::REM_RESET;
			used           <= sample_lane_packer_pkg::USED_RESET;
			sample_ready_o <= sample_lane_packer_pkg::READY_RESET;
			samp           <= '0;
		end else if (ce_i) begin
			cnt            <= next_cnt;
			rem            <= next_rem;
			sample_ready_o <= next_ready;
			if (load)
				used <= next_used;
			if (accept)
				samp[cnt] <= sample_i;
		end
	end

	assign lane_enable_o = used;

	default clocking cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	AST_M4_LANE0: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_4 && variant_i == sample_lane_packer_pkg::VAR_SINGLE
		|=> lane_octet_o[0] == $past(sample_i.ch[0][8:1])
		##1 lane_octet_o[0] == {$past(sample_i.ch[0][0], 2), 7'h00})
		else $error("mode 4 lane 0 octets wrong");
	AST_M4_LANE1: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_4 && variant_i == sample_lane_packer_pkg::VAR_DUAL
		|=> lane_octet_o[1] == {$past(sample_i.ch[1][4:0]), 3'h0} ##1 lane_octet_o[1] == 8'h00)
		else $error("mode 4 lane 1 octets wrong");
	AST_M5_QUAD: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_5 && variant_i == sample_lane_packer_pkg::VAR_QUAD
		|=> lane_octet_o[1] == $past(sample_i.ch[2][8:1]) ##1 lane_octet_o[1] == $past(sample_i.ch[3][8:1], 2))
		else $error("mode 5 lane 1 octets wrong");
	AST_M6_LANE2: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_6 && variant_i != sample_lane_packer_pkg::VAR_SINGLE
		|=> lane_octet_o[2] == {$past(samp[0].ch[1][0]), 3'h0, $past(sample_i.ch[1][8:5])})
		else $error("mode 6 lane 2 first octet wrong");
	AST_M7_LANE3: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_7 && variant_i == sample_lane_packer_pkg::VAR_QUAD
		|=> lane_valid_o[3] && lane_octet_o[3] == $past(sample_i.ch[3][8:1]))
		else $error("mode 7 lane 3 octet wrong");
	// Back-to-back frames are legal, so the lane may stay valid when a new frame loads on the last octet.
	AST_M8_THREE: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_8
		|=> lane_valid_o[0] [*3] ##0 lane_octet_o[0][2:0] == 3'h0 ##1 (!lane_valid_o[0] || $past(load)))
		else $error("mode 8 frame is not three octets");
	AST_M9_PAIR: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_9
		|=> lane_octet_o[0] == $past(samp[0].ch[0][8:1]) && lane_octet_o[1] == $past(sample_i.ch[0][8:1]))
		else $error("mode 9 even or odd sample on wrong lane");
	AST_M10_FIVE: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_10
		|=> lane_octet_o[0] == $past(samp[0].ch[0][8:1]) ##1 lane_valid_o[0] [*4] ##0 !lane_octet_o[0][0])
		else $error("mode 10 frame layout wrong");
	AST_SINGLE_LANES: assert property (
		load && variant_i == sample_lane_packer_pkg::VAR_SINGLE |=> lane_valid_o[7:2] == 6'h00)
		else $error("single variant drives a lane beyond its pair");
	AST_QUAD_ONLY: assert property (
		load && variant_i != sample_lane_packer_pkg::VAR_QUAD |=> lane_valid_o[7:4] == 4'h0)
		else $error("C or D lanes used outside quad variant");
	AST_M4_LANE2: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_4 && variant_i == sample_lane_packer_pkg::VAR_QUAD
		|=> lane_octet_o[2] == {$past(sample_i.ch[2][0]), 3'h0, $past(sample_i.ch[3][8:5])})
		else $error("mode 4 lane 2 first octet wrong");
	AST_M6_LANE0: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_6
		|=> lane_octet_o[0] == $past(samp[0].ch[0][8:1])
		##1 lane_octet_o[0] == {$past(samp[0].ch[0][0], 2), 3'h0, $past(sample_i.ch[0][8:5], 2)})
		else $error("mode 6 lane 0 octets wrong");
	AST_M7_ALL: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_7 && variant_i == sample_lane_packer_pkg::VAR_QUAD
		|=> lane_octet_o[2:0] == {$past(sample_i.ch[2][8:1]), $past(sample_i.ch[1][8:1]),
			$past(sample_i.ch[0][8:1])})
		else $error("mode 7 lanes 0 to 2 carry the wrong channels");
	AST_M10_ODD: assert property (
		load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_10
		|=> lane_octet_o[1] == $past(samp[1].ch[0][8:1]))
		else $error("mode 10 odd sample lane wrong");
	AST_NO_OVERRUN: assert property (
		load |-> rem == 3'h0)
		else $error("frame loaded before the previous one drained");

	COV_M10_FRAME: cover property (load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_10);
	COV_M8_STALL: cover property (load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_8 ##2 !sample_ready_o);
	COV_M4_DUAL: cover property (load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_4
		&& variant_i == sample_lane_packer_pkg::VAR_DUAL);
	COV_M9_SINGLE: cover property (load && lane_packing_mode_i == sample_lane_packer_pkg::MODE_9
		&& variant_i == sample_lane_packer_pkg::VAR_SINGLE);
endmodule
`default_nettype wire

/* lane_receiver_model.sv */
`timescale 1ns/100ps
`default_nettype none
module lane_receiver_model (
	input  wire logic                                           clk_i,
	input  wire logic                                           rst_i,
	input  wire logic                                           ce_i,
	input  wire logic [sample_lane_packer_pkg::NUM_LANES-1:0][7:0] lane_octet_i,
	input  wire logic [sample_lane_packer_pkg::NUM_LANES-1:0]      lane_valid_i,
	output logic      [sample_lane_packer_pkg::NUM_LANES-1:0][39:0] frame_o
);
	// Octets shift in at the low end, so octet 0 lands most significant and nibble 0 on top.
	// Only whole frames are judged, so stale octets above the frame width are masked off by the reader.
	always_ff @(posedge clk_i) begin
		for (int l = 0; l < sample_lane_packer_pkg::NUM_LANES; l++) begin
			if (rst_i) begin
				frame_o[l] <= 40'h0;
			end else if (ce_i && lane_valid_i[l]) begin
				frame_o[l] <= {frame_o[l][31:0], lane_octet_i[l]};
			end
		end
	end
endmodule
`default_nettype wire

/* sample_lane_packer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sample_lane_packer_bench;
	logic                                 clk_i = 1'b0;
	logic                                 rst_i = 1'b1;
	logic                                 ce_i = 1'b1;
	logic                                 gate = 1'b0;
	logic [3:0]                           mode = 4'h4;
	sample_lane_packer_pkg::variant_e     variant = sample_lane_packer_pkg::VAR_QUAD;
	logic                                 sample_valid = 1'b0;
	sample_lane_packer_pkg::sample_beat_s smp_in = '0;
	logic                                 ready;
	logic [7:0][7:0]                      octets;
	logic [7:0]                           valid;
	logic [7:0]                           enable;
	logic [7:0][39:0]                     frames;
	logic [7:0][39:0]                     ex;
	logic [8:0]                           sv [8][4];
	int                                   num_errors = 0;
	int                                   checks = 0;
	int                                   cycles = 0;

	always #2.5 clk_i = ~clk_i;

	sample_lane_packer sample_lane_packer_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lane_packing_mode_i(mode), .variant_i(variant),
		.sample_valid_i(sample_valid), .sample_i(smp_in), .sample_ready_o(ready), .lane_octet_o(octets),
		.lane_valid_o(valid), .lane_enable_o(enable));

	lane_receiver_model lane_receiver_model_i (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lane_octet_i(octets), .lane_valid_i(valid), .frame_o(frames));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Each ready wait already gives up after 50 cycles; this cap fails any run still going at cycle 3000.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic run(input logic [3:0] m, input sample_lane_packer_pkg::variant_e v, input int beats,
			input int octs, input int lanes, input logic [7:0] en);
		int n;
		logic [39:0] mask;
		mask = (40'h1 << (8 * octs)) - 40'h1;
		mode = m;
		variant = v;
		repeat (3) @(posedge clk_i);
		#1;
		for (int k = 0; k < beats; k++) begin
			for (int c = 0; c < 4; c++) smp_in.ch[c] = sv[k][c];
			sample_valid = 1'b1;
			n = 0;
			while (ready !== 1'b1 && n < 50) begin
				@(posedge clk_i);
				#1;
				n++;
			end
			@(posedge clk_i);
			#1;
		end
		sample_valid = 1'b0;
		if (gate) begin
			// Freeze mid-frame: the octets must stand and none may be skipped.
			ce_i = 1'b0;
			repeat (4) @(posedge clk_i);
			#1;
			ce_i = 1'b1;
		end
		repeat (12) @(posedge clk_i);
		#1;
		check("lane_enable", {32'h0, enable}, {32'h0, en});
		for (int l = 0; l < lanes; l++) check("lane_frame", frames[l] & mask, ex[l]);
		$display("test mode %0d variant %0d done", m, v);
	endtask

	task automatic test_mode4_quad();
		ex = '0;
		ex[0] = {sv[0][0], 3'h0, sv[0][1][8:5]};
		ex[1] = {sv[0][1][4:0], 3'h0, sv[0][2][8:1]};
		ex[2] = {sv[0][2][0], 3'h0, sv[0][3], 3'h0};
		run(sample_lane_packer_pkg::MODE_4, sample_lane_packer_pkg::VAR_QUAD, 1, 2, 3, 8'h07);
	endtask

	task automatic test_mode4_dual();
		ex = '0;
		ex[0] = {sv[0][0], 3'h0, sv[0][1][8:5]};
		ex[1] = {sv[0][1][4:0], 3'h0, 8'h00};
		run(sample_lane_packer_pkg::MODE_4, sample_lane_packer_pkg::VAR_DUAL, 1, 2, 2, 8'h03);
	endtask

	// Two frames back to back; the receiver keeps the second one.
	task automatic test_mode8_quad();
		ex = '0;
		for (int c = 0; c < 4; c++) ex[c] = {sv[2][c], 3'h0, sv[3][c], 3'h0};
		run(sample_lane_packer_pkg::MODE_8, sample_lane_packer_pkg::VAR_QUAD, 4, 3, 4, 8'h0f);
	endtask

	task automatic test_mode4_single();
		ex = '0;
		ex[0] = {sv[0][0], 3'h0, 4'h0};
		run(sample_lane_packer_pkg::MODE_4, sample_lane_packer_pkg::VAR_SINGLE, 1, 2, 1, 8'h01);
	endtask

	task automatic test_mode5_quad();
		ex = '0;
		ex[0] = {sv[0][0][8:1], sv[0][1][8:1]};
		ex[1] = {sv[0][2][8:1], sv[0][3][8:1]};
		run(sample_lane_packer_pkg::MODE_5, sample_lane_packer_pkg::VAR_QUAD, 1, 2, 2, 8'h03);
	endtask

	task automatic test_mode6_dual();
		ex = '0;
		ex[0] = {sv[0][0], 3'h0, sv[1][0][8:5]};
		ex[1] = {sv[1][0][4:0], 3'h0, sv[0][1][8:1]};
		ex[2] = {sv[0][1][0], 3'h0, sv[1][1], 3'h0};
		run(sample_lane_packer_pkg::MODE_6, sample_lane_packer_pkg::VAR_DUAL, 2, 2, 3, 8'h07);
	endtask

	task automatic test_mode7_quad();
		ex = '0;
		for (int c = 0; c < 4; c++) ex[c] = {32'h0, sv[0][c][8:1]};
		run(sample_lane_packer_pkg::MODE_7, sample_lane_packer_pkg::VAR_QUAD, 1, 1, 4, 8'h0f);
	endtask

	task automatic test_mode8_dual();
		ex = '0;
		for (int c = 0; c < 2; c++) ex[c] = {sv[0][c], 3'h0, sv[1][c], 3'h0};
		run(sample_lane_packer_pkg::MODE_8, sample_lane_packer_pkg::VAR_DUAL, 2, 3, 2, 8'h03);
	endtask

	task automatic test_mode9_single();
		ex = '0;
		ex[0] = {32'h0, sv[0][0][8:1]};
		ex[1] = {32'h0, sv[1][0][8:1]};
		run(sample_lane_packer_pkg::MODE_9, sample_lane_packer_pkg::VAR_SINGLE, 2, 1, 2, 8'h03);
	endtask

	task automatic test_mode10_dual();
		ex = '0;
		for (int l = 0; l < 4; l++) begin
			ex[l] = {sv[l%2][l/2], 1'b0, sv[l%2+2][l/2], 1'b0, sv[l%2+4][l/2], 1'b0, sv[l%2+6][l/2], 1'b0};
		end
		gate = 1'b1;
		run(sample_lane_packer_pkg::MODE_10, sample_lane_packer_pkg::VAR_DUAL, 8, 5, 4, 8'h0f);
		gate = 1'b0;
	endtask

	initial begin
		// Distinct values per beat and channel expose any swapped slot or shifted nibble.
		for (int k = 0; k < 8; k++) begin
			for (int c = 0; c < 4; c++) sv[k][c] = 9'((k * 83 + c * 155 + 167) % 512);
		end
		repeat (16) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		test_mode4_quad();
		test_mode4_single();
		test_mode4_dual();
		test_mode5_quad();
		test_mode6_dual();
		test_mode7_quad();
		test_mode8_dual();
		test_mode8_quad();
		test_mode9_single();
		test_mode10_dual();
		conclude();
	end
endmodule
`default_nettype wire
